// file: src/acw_pkg.sv
// Purpose: shared constants for the converter clock and warmup sequencer
// Assumes: AHB-Lite register port, 32-bit words, byte addresses below
// Notes:   field positions are low bits of each field
package acw_pkg;
   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ACW_CTRL_OFS   = 8'h00;
   localparam logic [7:0] ACW_CFG_OFS    = 8'h04;
   localparam logic [7:0] ACW_SCHED_OFS  = 8'h08;
   localparam logic [7:0] ACW_CMD_OFS    = 8'h0C;
   localparam logic [7:0] ACW_STATUS_OFS = 8'h10;
   localparam logic [7:0] ACW_RESULT_OFS = 8'h14;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_POLICY_POS  = 0;   // warmup_policy [1:0]
   localparam int CTRL_CORDIV_POS  = 2;   // core_clock_divider [4:2]
   localparam int CTRL_TBASE_POS   = 5;   // warmup_interval_count [12:5]
   localparam int CTRL_SUSP_POS    = 13;  // clock suspend
   localparam int CTRL_CONT_POS    = 14;  // continuous conversions
   localparam int CFG_MODE_POS     = 0;   // conversion_mode [1:0]
   localparam int CFG_REF_POS      = 2;   // reference_select
   localparam int CFG_AVG_POS      = 3;   // digital_average_count [5:3]
   localparam int CFG_FOSR_POS     = 6;   // fast_oversample_ratio [8:6]
   localparam int CFG_POSR_POS     = 9;   // precise_oversample_ratio [10:9]
   localparam int CMD_START_POS    = 0;
   localparam int CMD_CHAN_POS     = 4;   // channel [7:4]
   // ****************************************************************
   // reset values and counts
   // ****************************************************************
   localparam logic [14:0] CTRL_RST       = 15'h0000;
   localparam logic [10:0] CFG_RST        = 11'h000;
   localparam logic [7:0]  SCHED_RST      = 8'h01;
   localparam logic [2:0]  WARM_OFF_IVS   = 3'h5;  // intervals from powered down
   localparam logic [2:0]  WARM_STBY_IVS  = 3'h1;  // intervals from standby
   localparam logic [2:0]  SMP_DIV_FAST   = 3'h4;  // front-end sample divide
   localparam logic [2:0]  SMP_DIV_PREC   = 3'h5;
   localparam logic [10:0] CONV_ADD_FAST  = 11'h002; // 4*ratio + 2
   localparam logic [10:0] CONV_ADD_PREC  = 11'h007; // 5*ratio + 7
   localparam logic [10:0] CHAN_SW_EXTRA  = 11'h002; // channel switch cycles
   localparam logic [2:0]  AVG_MAX_CODE   = 3'h4;  // 16 conversions
   typedef enum logic [1:0] {POL_OFF, POL_STANDBY, POL_STAY} acw_policy_t;
   typedef enum logic [1:0] {MODE_NORMAL, MODE_HIGH_RATE, MODE_PRECISION, MODE_RSVD} acw_mode_t;
endpackage

// file: src/acw_top.sv
// Purpose: clock division, warmup sequencing and conversion timing for an
//          incremental converter, with an AHB-Lite register slave
// Assumes: sys_clk is also the incoming converter clock; the core source
//          clock and conversion clock are tick strobes derived from it
// Notes:   one result word is held; a new one while unread sets overflow
// Contract
// - registers and result read on bus clock
// - warmup_interval_count and timer run from core source clock
// - conversion clock divides core clock, drives front-end
// - divider zero with core divider nonzero means one
// - ratio from fast field or precision field
// - samples every 4 or 5 conversion clocks
// - average 1..16 conversions into one word
// - warmup 5 us powered down, 1 us standby
// - five intervals from off, one from standby
// - policy picks off, standby or stay powered
// - five intervals at power up and config change
// - status flag shows warmed up
// - conversion lasts four times ratio plus two; precision mode takes five times ratio plus seven
// - channel switch adds two tristate cycles; precision mode adds none
// - suspend stops conversion clock between conversions
// - core divider zero passes clock through
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module acw_top (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [11:0] afe_data,
   output logic             afe_power_on,
   output logic             afe_standby,
   output logic             afe_clk_run,
   output logic             afe_sample,
   output logic             afe_tristate,
   output logic      [3:0]  afe_channel,
   output logic             result_write
);
   import acw_pkg::*;
   typedef enum logic [2:0] {ST_OFF, ST_STBY, ST_WARM, ST_READY, ST_CONV} acw_state_t;

   // ****************************************************************
   // registers and state
   // ****************************************************************
   logic [14:0] ctrl_r, ctrl_nxt;
   logic [10:0] cfg_r, cfg_nxt;
   logic [7:0]  sched_r, sched_nxt;
   logic        wr_r, wr_nxt;
   logic [7:0]  wa_r, wa_nxt;
   logic [31:0] hrdata_nxt;
   logic        pend_r, pend_nxt;
   logic [3:0]  chan_r, chan_nxt;
   logic [3:0]  last_r, last_nxt;
   logic        cold_r, cold_nxt;
   logic [15:0] res_r, res_nxt;
   logic [3:0]  rch_r, rch_nxt;
   logic        val_r, val_nxt;
   logic        ovf_r, ovf_nxt;
   logic [11:0] dsy1_r, dsy2_r;
   acw_state_t  st_r, st_nxt;
   logic [2:0]  ccnt_r, ccnt_nxt;
   logic [7:0]  acnt_r, acnt_nxt;
   logic [7:0]  tcnt_r, tcnt_nxt;
   logic [2:0]  wleft_r, wleft_nxt;
   logic [10:0] cleft_r, cleft_nxt;
   logic [10:0] xleft_r, xleft_nxt;
   logic [2:0]  scnt_r, scnt_nxt;
   logic [4:0]  aleft_r, aleft_nxt;
   logic [23:0] sacc_r, sacc_nxt;
   logic [19:0] aacc_r, aacc_nxt;
   logic        pwr_nxt, stby_nxt, run_nxt, smp_nxt, tri_nxt, rw_nxt;

   // ****************************************************************
   // field decode and derived timing
   // ****************************************************************
   logic        acc, rd_res, core_tick, adc_tick, iv_tick, prec;
   logic [7:0]  eff_div;
   logic [2:0]  smp_div, avg_code;
   logic [3:0]  osr_sh;
   logic [10:0] conv_len;
   logic [4:0]  avg_n;
   logic [19:0] conv_val;
   acw_policy_t policy;

   assign acc    = hsel && hready && htrans[1];
   assign rd_res = acc && !hwrite && (haddr[7:0] == ACW_RESULT_OFS);
   assign policy = acw_policy_t'(ctrl_r[CTRL_POLICY_POS +: 2]);
   assign prec   = (cfg_r[CFG_MODE_POS +: 2] == MODE_PRECISION);
   // divide by 1 is not allowed behind a running core divider
   assign eff_div = (ctrl_r[CTRL_CORDIV_POS +: 3] != 3'h0 && sched_r == 8'h00) ? 8'h01 : sched_r;
   // core source clock: divider value 0 passes every edge
   assign core_tick = (ccnt_r >= ctrl_r[CTRL_CORDIV_POS +: 3]);
   assign adc_tick = core_tick && afe_clk_run && (acnt_r >= eff_div);
   assign iv_tick  = core_tick && (tcnt_r >= ctrl_r[CTRL_TBASE_POS +: 8]);
   assign smp_div  = prec ? SMP_DIV_PREC : SMP_DIV_FAST;
   // ratio shift: fast ratio 2<<code, precise ratio 16<<code
   assign osr_sh   = prec ? (4'h4 + {2'h0, cfg_r[CFG_POSR_POS +: 2]})
                          : (4'h1 + {1'h0, cfg_r[CFG_FOSR_POS +: 3]});
   assign conv_len = prec ? ((11'h001 << osr_sh) * 11'h005 + CONV_ADD_PREC)
                          : ((11'h001 << osr_sh) * 11'h004 + CONV_ADD_FAST);
   assign avg_code = (cfg_r[CFG_AVG_POS +: 3] > AVG_MAX_CODE) ? AVG_MAX_CODE : cfg_r[CFG_AVG_POS +: 3];
   assign avg_n    = 5'h01 << avg_code;
   assign conv_val = 20'(sacc_r >> osr_sh);

   // ****************************************************************
   // bus slave next state
   // ****************************************************************
   always_comb begin
      logic chg;
      chg        = 1'b0;
      ctrl_nxt   = ctrl_r;
      cfg_nxt    = cfg_r;
      sched_nxt  = sched_r;
      wr_nxt     = acc && hwrite;
      wa_nxt     = haddr[7:0];
      hrdata_nxt = 32'h0000_0000;
      pend_nxt   = pend_r;
      chan_nxt   = chan_r;
      // a taken start clears the request unless continuous; a new start below wins
      if (st_r == ST_READY && pend_r && !cold_r)
         pend_nxt = ctrl_r[CTRL_CONT_POS];
      // data phase write
      if (wr_r) begin
         case (wa_r)
            ACW_CTRL_OFS: ctrl_nxt = hwdata[14:0];
            ACW_CFG_OFS: begin
               cfg_nxt = hwdata[10:0];
               chg = (hwdata[CFG_MODE_POS +: 3] != cfg_r[CFG_MODE_POS +: 3]);
            end
            ACW_SCHED_OFS: begin
               sched_nxt = hwdata[7:0];
               chg = (hwdata[7:0] != sched_r);
            end
            ACW_CMD_OFS: begin
               if (hwdata[CMD_START_POS]) begin
                  pend_nxt = 1'b1;
                  chan_nxt = hwdata[CMD_CHAN_POS +: 4];
               end
            end
            default: ;
         endcase
      end
      // a mode, reference or conversion divider change forces a cold warmup; the set wins over the clear
      cold_nxt = chg || (cold_r && !(st_r == ST_WARM && iv_tick && wleft_r == 3'h1));
      // address phase read data, shown in the data phase
      if (acc && !hwrite) begin
         case (haddr[7:0])
            ACW_CTRL_OFS:   hrdata_nxt = {17'h0, ctrl_r};
            ACW_CFG_OFS:    hrdata_nxt = {21'h0, cfg_r};
            ACW_SCHED_OFS:  hrdata_nxt = {24'h0, sched_r};
            ACW_STATUS_OFS: hrdata_nxt = {27'h0, pend_r, ovf_r, val_r, st_r == ST_CONV,
                                          st_r == ST_READY || st_r == ST_CONV};
            ACW_RESULT_OFS: hrdata_nxt = {12'h0, rch_r, res_r};
            default:        hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // bus registers, on the bus clock
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_r    <= CTRL_RST;
         cfg_r     <= CFG_RST;
         sched_r   <= SCHED_RST;
         wr_r      <= 1'b0;
         wa_r      <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         pend_r    <= 1'b0;
         chan_r    <= 4'h0;
         cold_r    <= 1'b1;
      end else begin
         ctrl_r    <= ctrl_nxt;
         cfg_r     <= cfg_nxt;
         sched_r   <= sched_nxt;
         wr_r      <= wr_nxt;
         wa_r      <= wa_nxt;
         hrdata    <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         pend_r    <= pend_nxt;
         chan_r    <= chan_nxt;
         cold_r    <= cold_nxt;
      end
   end

   // ****************************************************************
   // warmup and conversion sequencer next state
   // ****************************************************************
   always_comb begin
      st_nxt    = st_r;
      ccnt_nxt  = core_tick ? 3'h0 : ccnt_r + 3'h1;
      acnt_nxt  = acnt_r;
      tcnt_nxt  = (st_r != ST_WARM) ? 8'h00 : (core_tick ? (iv_tick ? 8'h00 : tcnt_r + 8'h01) : tcnt_r);
      wleft_nxt = wleft_r;
      cleft_nxt = cleft_r;
      xleft_nxt = xleft_r;
      scnt_nxt  = scnt_r;
      aleft_nxt = aleft_r;
      sacc_nxt  = sacc_r;
      aacc_nxt  = aacc_r;
      last_nxt  = last_r;
      res_nxt   = res_r;
      rch_nxt   = rch_r;
      val_nxt   = val_r && !rd_res;
      ovf_nxt   = ovf_r && !rd_res;
      smp_nxt   = 1'b0;
      tri_nxt   = 1'b0;
      rw_nxt    = 1'b0;
      case (st_r)
         ST_OFF, ST_STBY: begin
            if (pend_r || policy == POL_STAY) begin
               st_nxt    = ST_WARM;
               wleft_nxt = (st_r == ST_OFF || cold_r) ? WARM_OFF_IVS : WARM_STBY_IVS;
            end
         end
         ST_WARM: begin
            if (iv_tick) begin
               wleft_nxt = wleft_r - 3'h1;
               if (wleft_r == 3'h1)
                  st_nxt = ST_READY;
            end
         end
         ST_READY: begin
            if (cold_r) begin
               st_nxt    = ST_WARM;
               wleft_nxt = WARM_OFF_IVS;
            end else if (pend_r) begin
               st_nxt    = ST_CONV;
               cleft_nxt = conv_len;
               xleft_nxt = (!prec && chan_r != last_r) ? CHAN_SW_EXTRA : 11'h000;
               aleft_nxt = avg_n;
               scnt_nxt  = 3'h0;
               sacc_nxt  = 24'h000000;
               aacc_nxt  = 20'h00000;
               last_nxt  = chan_r;
            end else if (policy == POL_OFF) begin
               st_nxt = ST_OFF;
            end else if (policy == POL_STANDBY) begin
               st_nxt = ST_STBY;
            end
         end
         ST_CONV: begin
            if (adc_tick && xleft_r != 11'h000) begin
               xleft_nxt = xleft_r - 11'h001;
               tri_nxt   = 1'b1;
            end else if (adc_tick) begin
               scnt_nxt = (scnt_r == smp_div - 3'h1) ? 3'h0 : scnt_r + 3'h1;
               // no sample in the pipeline tail: exactly ratio samples per conversion
               if (scnt_r == smp_div - 3'h1 && cleft_r > (prec ? CONV_ADD_PREC : CONV_ADD_FAST)) begin
                  smp_nxt  = 1'b1;
                  sacc_nxt = sacc_r + {12'h000, dsy2_r};
               end
               cleft_nxt = cleft_r - 11'h001;
               if (cleft_r == 11'h001) begin
                  // conversion done; next one on the same slot starts at once
                  aacc_nxt  = aacc_r + conv_val;
                  aleft_nxt = aleft_r - 5'h01;
                  sacc_nxt  = 24'h000000;
                  scnt_nxt  = 3'h0;
                  cleft_nxt = conv_len;
                  if (aleft_r == 5'h01) begin
                     rw_nxt    = 1'b1;
                     res_nxt   = 16'((aacc_r + conv_val) >> avg_code);
                     rch_nxt   = last_r;
                     val_nxt   = 1'b1;
                     ovf_nxt   = ovf_r || (val_r && !rd_res);
                     aleft_nxt = avg_n;
                     aacc_nxt  = 20'h00000;
                     if (!(ctrl_r[CTRL_CONT_POS] && pend_r && !cold_r && chan_r == last_r))
                        st_nxt = ST_READY;
                  end
               end
            end
         end
         default: st_nxt = ST_OFF;
      endcase
      // suspend holds the conversion clock outside warmup and conversion
      run_nxt  = !ctrl_r[CTRL_SUSP_POS] || st_nxt == ST_WARM || st_nxt == ST_CONV;
      acnt_nxt = !run_nxt ? 8'h00 : (core_tick ? ((acnt_r >= eff_div) ? 8'h00 : acnt_r + 8'h01) : acnt_r);
      pwr_nxt  = st_nxt != ST_OFF && st_nxt != ST_STBY;
      stby_nxt = st_nxt == ST_STBY;
   end

   // sequencer registers and front-end outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r         <= ST_OFF;
         ccnt_r       <= 3'h0;
         acnt_r       <= 8'h00;
         tcnt_r       <= 8'h00;
         wleft_r      <= WARM_OFF_IVS;
         cleft_r      <= 11'h000;
         xleft_r      <= 11'h000;
         scnt_r       <= 3'h0;
         aleft_r      <= 5'h01;
         sacc_r       <= 24'h000000;
         aacc_r       <= 20'h00000;
         last_r       <= 4'h0;
         res_r        <= 16'h0000;
         rch_r        <= 4'h0;
         val_r        <= 1'b0;
         ovf_r        <= 1'b0;
         dsy1_r       <= 12'h000;
         dsy2_r       <= 12'h000;
         afe_power_on <= 1'b0;
         afe_standby  <= 1'b0;
         afe_clk_run  <= 1'b1;
         afe_sample   <= 1'b0;
         afe_tristate <= 1'b0;
         afe_channel  <= 4'h0;
         result_write <= 1'b0;
      end else begin
         st_r         <= st_nxt;
         ccnt_r       <= ccnt_nxt;
         acnt_r       <= acnt_nxt;
         tcnt_r       <= tcnt_nxt;
         wleft_r      <= wleft_nxt;
         cleft_r      <= cleft_nxt;
         xleft_r      <= xleft_nxt;
         scnt_r       <= scnt_nxt;
         aleft_r      <= aleft_nxt;
         sacc_r       <= sacc_nxt;
         aacc_r       <= aacc_nxt;
         last_r       <= last_nxt;
         res_r        <= res_nxt;
         rch_r        <= rch_nxt;
         val_r        <= val_nxt;
         ovf_r        <= ovf_nxt;
         dsy1_r       <= afe_data;  // front-end data crosses in
         dsy2_r       <= dsy1_r;
         afe_power_on <= pwr_nxt;
         afe_standby  <= stby_nxt;
         afe_clk_run  <= run_nxt;
         afe_sample   <= smp_nxt;
         afe_tristate <= tri_nxt;
         afe_channel  <= last_nxt;
         result_write <= rw_nxt;
      end
   end
endmodule

// file: bench/acw_assertions.sv
// Purpose: port-level checks on the converter sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every acw_top instance
`timescale 1ns/100ps
module acw_checker (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        afe_power_on,
   input wire logic        afe_standby,
   input wire logic        afe_clk_run,
   input wire logic        afe_sample,
   input wire logic        afe_tristate,
   input wire logic        result_write
);
   logic rd_r;
   logic rd_nxt;
   // ****************************************************************
   // read data phase tracker
   // ****************************************************************
   // a read address phase accepted in this cycle
   always_comb begin
      rd_nxt = rst_n && hsel && hready && htrans[1] && !hwrite;
   end
   always_ff @(posedge sys_clk) begin
      rd_r <= rd_nxt;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ****************************************************************
   // assertions
   // ****************************************************************
   chk_bus_ready: assert property (hreadyout)
      else $error("hreadyout dropped");
   chk_resp_okay: assert property (!hresp)
      else $error("error response seen");
   chk_idle_rdata: assert property (!rd_r |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   chk_write_pulse: assert property (result_write |=> !result_write)
      else $error("result write longer than one cycle");
   chk_sample_gap: assert property (afe_sample |=> !afe_sample [*3])
      else $error("front-end samples too close");
   chk_sample_power: assert property (afe_sample |-> afe_power_on && !afe_standby && afe_clk_run)
      else $error("sample taken while unpowered or clock stopped");
   chk_write_warm: assert property (result_write |-> $past(afe_power_on))
      else $error("result posted without a warm converter");
   chk_switch_quiet: assert property (afe_tristate |-> !afe_sample && afe_power_on)
      else $error("sample during channel switch cycle");
   chk_standby_off: assert property (afe_standby |-> !afe_power_on)
      else $error("standby and full power together");
endmodule
bind acw_top acw_checker u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .afe_power_on(afe_power_on),
   .afe_standby(afe_standby), .afe_clk_run(afe_clk_run), .afe_sample(afe_sample),
   .afe_tristate(afe_tristate), .result_write(result_write));

// file: bench/acw_afe_model.sv
// Purpose: analog front-end stand-in feeding sample values
// Assumes: level per channel while powered
// Notes:   unpowered output flips every cycle
`timescale 1ns/100ps
module acw_afe_model (
   input  wire logic        sys_clk,
   input  wire logic        afe_power_on,
   input  wire logic [3:0]  afe_channel,
   output logic      [11:0] afe_data
);
   logic [11:0] idle_r = 12'hA5A;
   // unpowered front-end shows no stable level
   always_ff @(posedge sys_clk) begin
      idle_r <= ~idle_r;
   end
   // powered: level depends on the selected channel only
   assign afe_data = afe_power_on ? {afe_channel, 8'h5A} : idle_r;
endmodule

// file: bench/acw_top_tb.sv
// Purpose: register-driven test of warmup and conversion timing
// Assumes: zero wait-state slave, interval count 3 (4 core ticks)
// Notes:   timing is measured in sys_clk cycles
`timescale 1ns/100ps
module acw_top_tb;
   import acw_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, afe_power_on, afe_standby, afe_clk_run, afe_sample, afe_tristate, result_write;
   logic [3:0]  afe_channel;
   logic [11:0] afe_data;
   int          errors = 0, cmp_count = 0, cyc = 0, smp = 0, tri_n = 0;
   int          t, t0, t1, toff, tsb, s0;
   logic [7:0]  ra [5] = '{ACW_CTRL_OFS, ACW_CFG_OFS, ACW_SCHED_OFS, ACW_STATUS_OFS, 8'h18};
   logic [31:0] re [5] = '{{17'h0, CTRL_RST}, {21'h0, CFG_RST}, {24'h0, SCHED_RST}, 32'h0, 32'h0};
   // case 2: core clock divided by 3, high-rate mode, conversion clock within its limit
   logic [31:0] ctl [8] = '{32'h4062, 32'h4062, 32'h406A, 32'h4062, 32'h4062, 32'h4062, 32'h4062, 32'h4062};
   logic [31:0] cfg [8] = '{32'h0, 32'h0, 32'h1, 32'h40, 32'h241, 32'h42, 32'h8, 32'h20};
   logic [31:0] sch [8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] gap [8] = '{32'd10, 32'd20, 32'd60, 32'd18, 32'd18, 32'd87, 32'd20, 32'd160};
   logic [31:0] nsm [8] = '{32'd2, 32'd2, 32'd2, 32'd4, 32'd4, 32'd16, 32'd4, 32'd32};
   // 100 MHz bus and converter clock
   always #5 sys_clk = ~sys_clk;
   // cycle, sample and switch-cycle counters
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      smp <= smp + int'(afe_sample === 1'b1);
      tri_n <= tri_n + int'(afe_tristate === 1'b1);
   end
   acw_top uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .afe_data(afe_data), .afe_power_on(afe_power_on), .afe_standby(afe_standby),
      .afe_clk_run(afe_clk_run), .afe_sample(afe_sample), .afe_tristate(afe_tristate),
      .afe_channel(afe_channel), .result_write(result_write));
   acw_afe_model u_afe (
      .sys_clk(sys_clk), .afe_power_on(afe_power_on), .afe_channel(afe_channel), .afe_data(afe_data));
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic results();
      if (errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for the edge at which hready is sampled high, bounded
   task automatic bus_edge();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         errors++;
         results();
      end
   endtask
   // single word transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      bus_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      bus_edge();
      rd = hrdata;
   endtask
   // bounded wait for result write (sel 0) or power on (sel 1)
   task automatic wait_hi(input int sel, output int tt);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!((sel == 0) ? result_write === 1'b1 : afe_power_on === 1'b1) && n < 3000);
      if (n >= 3000) begin
         errors++;
         results();
      end
      tt = cyc;
   endtask
   // start one conversion, time from power on to result
   task automatic conv(input logic [3:0] ch, output int d);
      xfer(1'b1, ACW_CMD_OFS, {24'h0, ch, 4'h1});
      wait_hi(1, t0);
      wait_hi(0, t1);
      d = t1 - t0;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check({29'h0, hreadyout, hresp, afe_clk_run}, 32'h5);
      xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
      xfer(1'b1, ACW_STATUS_OFS, 32'hFFFF_FFFF);
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, ra[i], 32'h0);
         check(rd, re[i]);
      end
      // software keeps interval count and conversion clock legal
      xfer(1'b1, ACW_CTRL_OFS, 32'h60);
      xfer(1'b1, ACW_SCHED_OFS, 32'h0);
      conv(4'h0, toff);
      xfer(1'b0, ACW_RESULT_OFS, 32'h0);
      check(rd, 32'h5A);
      xfer(1'b0, ACW_STATUS_OFS, 32'h0);
      check(rd & 32'h7, 32'h0);
      xfer(1'b1, ACW_CTRL_OFS, 32'h61);
      conv(4'h0, t);
      xfer(1'b0, ACW_RESULT_OFS, 32'h0);
      check({31'h0, afe_standby}, 32'h1);
      conv(4'h0, tsb);
      check(32'(toff - tsb), 32'd16);
      xfer(1'b1, ACW_CFG_OFS, 32'h4);
      conv(4'h0, t);
      check(32'(t), 32'(toff));
      xfer(1'b1, ACW_CTRL_OFS, 32'h62);
      conv(4'h0, t);
      xfer(1'b0, ACW_STATUS_OFS, 32'h0);
      check({29'h0, rd[0], afe_power_on, afe_standby}, 32'h6);
      s0 = tri_n;
      conv(4'h3, t);
      check(32'(tri_n - s0), 32'h2);
      conv(4'h3, tsb);
      check(32'(t - tsb), 32'h2);
      xfer(1'b0, ACW_RESULT_OFS, 32'h0);
      check(rd, 32'h3035A);
      xfer(1'b1, ACW_CTRL_OFS, 32'h2060);
      xfer(1'b0, ACW_STATUS_OFS, 32'h0);
      check({31'h0, afe_clk_run}, 32'h0);
      xfer(1'b1, ACW_CMD_OFS, 32'h31);
      wait_hi(1, t0);
      check({31'h0, afe_clk_run}, 32'h1);
      wait_hi(0, t1);
      xfer(1'b0, ACW_RESULT_OFS, 32'h0);
      check({31'h0, afe_clk_run}, 32'h0);
      // continuous conversions: spacing and samples per word
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, ACW_CFG_OFS, cfg[i]);
         xfer(1'b1, ACW_SCHED_OFS, sch[i]);
         xfer(1'b1, ACW_CTRL_OFS, ctl[i]);
         xfer(1'b1, ACW_CMD_OFS, 32'h1);
         wait_hi(0, t0);
         wait_hi(0, t0);
         s0 = smp;
         wait_hi(0, t1);
         check(32'(t1 - t0), gap[i]);
         if (nsm[i] != 32'd0) check(32'(smp - s0), nsm[i]);
         xfer(1'b1, ACW_CTRL_OFS, 32'h62);
         wait_hi(0, t1);
         xfer(1'b0, ACW_RESULT_OFS, 32'h0);
         check(rd & 32'hF_FFFF, 32'h5A);
      end
      results();
   end
endmodule
